// ---- design/lfa_defs.svh ----
// lfa_defs.svh: timing counts and widths for the laser fault annunciator
// assumes a single 10 MHz clock; included by bare name
`ifndef LFA_DEFS_SVH
`define LFA_DEFS_SVH

// ----------------------------------------------------------------
// clock
// ----------------------------------------------------------------
`define LFA_CLK_KHZ     10000
`define LFA_CNT_W       24

// ----------------------------------------------------------------
// times in ms and their cycle counts
// ----------------------------------------------------------------
`define LFA_QUAL_MS     420
`define LFA_QUAL_CYC    (`LFA_QUAL_MS * `LFA_CLK_KHZ)
`define LFA_PAUSE_MS    500
`define LFA_PAUSE_CYC   (`LFA_PAUSE_MS * `LFA_CLK_KHZ)
`define LFA_BLINK_ON_MS  150
`define LFA_BLINK_ON_CYC (`LFA_BLINK_ON_MS * `LFA_CLK_KHZ)
`define LFA_BLINK_OFF_MS 150
`define LFA_BLINK_OFF_CYC (`LFA_BLINK_OFF_MS * `LFA_CLK_KHZ)
`define LFA_FLASH_MS    250
`define LFA_FLASH_CYC   (`LFA_FLASH_MS * `LFA_CLK_KHZ)

// ----------------------------------------------------------------
// blink codes
// ----------------------------------------------------------------
`define LFA_CODE_UV     2'h1
`define LFA_CODE_OV     2'h2
`define LFA_CODE_SENSE  2'h3

`endif

// ---- design/lfa_pkg.sv ----
// lfa_pkg.sv: types shared by the laser fault annunciator
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none

package lfa_pkg;

  // ----------------------------------------------------------------
  // pins and outputs
  // ----------------------------------------------------------------
  typedef struct packed {
    logic laser_enable;
    logic over_temp;
    logic under_volt;
    logic over_volt;
    logic supply_monitor_fault;
    logic board_fault;
    logic pwm_active;
  } lfa_pins_s;

  typedef struct packed {
    logic laser_ready;
    logic laser_ok;
    logic supply_fault_out;
    logic overtemp_fault;
    logic lase_ind;
    logic voltage_ok;
    logic temp_ok;
  } lfa_status_s;

  typedef struct packed {
    logic ready_lamp;
    logic supply_lamp;
    logic lase_lamp;
  } lfa_lamps_s;

  // ----------------------------------------------------------------
  // annunciation modes and blink states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    LFA_M_NORMAL, LFA_M_INTERLOCK, LFA_M_OVERTEMP, LFA_M_SUPPLY, LFA_M_BOARD
  } lfa_mode_e;

  typedef enum logic [1:0] {
    LFA_B_IDLE, LFA_B_ON, LFA_B_OFF, LFA_B_PAUSE
  } lfa_blink_e;

endpackage

`default_nettype wire

// ---- design/lfa_blink.sv ----
// lfa_blink.sv: blink code generator for the supply lamp
// assumes code_i is steady while active_i is high
`include "lfa_defs.svh"
`default_nettype none

module lfa_blink
  import lfa_pkg::*;
#(
  parameter int unsigned ON_CYC    = `LFA_BLINK_ON_CYC,
  parameter int unsigned OFF_CYC   = `LFA_BLINK_OFF_CYC,
  parameter int unsigned PAUSE_CYC = `LFA_PAUSE_CYC
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       clock_en,
  input  wire logic       reset_n,
  // code request
  input  wire logic [1:0] code_i,
  input  wire logic       active_i,
  // lamp drive
  output logic            lamp_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  lfa_blink_e                 state_r, state_nxt;
  logic [`LFA_CNT_W-1:0]      tmr_r, tmr_nxt;
  logic [1:0]                 blinks_r, blinks_nxt;
  logic                       lamp_r;
  wire                        tmr_done = (tmr_r == '0);

  always_comb begin
    state_nxt  = state_r;
    tmr_nxt    = tmr_done ? tmr_r : tmr_r - 1'b1;
    blinks_nxt = blinks_r;
    case (state_r)
      LFA_B_IDLE: begin
        blinks_nxt = 2'h0;
        if (active_i && code_i != 2'h0) begin
          state_nxt = LFA_B_ON;
          tmr_nxt   = `LFA_CNT_W'(ON_CYC - 1);
        end
      end
      LFA_B_ON: begin
        if (tmr_done) begin
          blinks_nxt = blinks_r + 2'h1;
          if (blinks_r + 2'h1 == code_i) begin
            state_nxt = LFA_B_PAUSE;
            tmr_nxt   = `LFA_CNT_W'(PAUSE_CYC - 1);
          end else begin
            state_nxt = LFA_B_OFF;
            tmr_nxt   = `LFA_CNT_W'(OFF_CYC - 1);
          end
        end
      end
      LFA_B_OFF: begin
        if (tmr_done) begin
          state_nxt = LFA_B_ON;
          tmr_nxt   = `LFA_CNT_W'(ON_CYC - 1);
        end
      end
      LFA_B_PAUSE: begin
        if (tmr_done) begin
          state_nxt  = LFA_B_ON;
          blinks_nxt = 2'h0;
          tmr_nxt    = `LFA_CNT_W'(ON_CYC - 1);
        end
      end
      default: state_nxt = LFA_B_IDLE;
    endcase
    if (!active_i) begin
      state_nxt = LFA_B_IDLE;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_r  <= LFA_B_IDLE;
      tmr_r    <= '0;
      blinks_r <= 2'h0;
      lamp_r   <= 1'b0;
    end else if (clock_en) begin
      state_r  <= state_nxt;
      tmr_r    <= tmr_nxt;
      blinks_r <= blinks_nxt;
      lamp_r   <= (state_nxt == LFA_B_ON);
    end
  end

  assign lamp_o = lamp_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_code_count;
    @(posedge clock) disable iff (!reset_n)
      (state_r == LFA_B_PAUSE) |-> (blinks_r == code_i);
  endproperty
  a_code_count: assert property (p_code_count) else $error("blink count differs from code");

  property p_pause_dark;
    @(posedge clock) disable iff (!reset_n)
      (state_r == LFA_B_PAUSE) && !tmr_done && active_i |-> !lamp_r;
  endproperty
  a_pause_dark: assert property (p_pause_dark) else $error("lamp lit during pause");

endmodule // lfa_blink

`default_nettype wire

// ---- design/lfa_top.sv ----
// lfa_top.sv: fault supervision and status annunciation for the laser
// assumes all pin inputs are asynchronous; reset_n is the power-on reset
// How it works
// - interlock is never latched, follows enable
// - enable open: ready lamp off; restored: on
// - over-temperature: ready lamp flashes, lasing inhibited
// - after power cycle, ready steady, lasing enabled
// - under-voltage only after qualified low supply
// - under-voltage: supply lamp one-blink code
// - over-voltage only after qualified high supply
// - over-voltage: supply lamp two-blink code
// - supply monitor fault: three-blink code, latched
// - board fault: both lamps flash continuously
// - voltage faults latched until power cycle
// - interlock output pattern, supply lamp green
// - over-temperature output pattern
// - under-voltage output pattern
// - over-voltage and monitor share supply pattern
// - board fault output pattern
// - code, half-second pause, repeat until reset
`include "lfa_defs.svh"
`default_nettype none

module lfa_top
  import lfa_pkg::*;
#(
  parameter int unsigned QUAL_CYC  = `LFA_QUAL_CYC,
  parameter int unsigned PAUSE_CYC = `LFA_PAUSE_CYC,
  parameter int unsigned ON_CYC    = `LFA_BLINK_ON_CYC,
  parameter int unsigned OFF_CYC   = `LFA_BLINK_OFF_CYC,
  parameter int unsigned FLASH_CYC = `LFA_FLASH_CYC
) (
  // clock and reset
  input  wire logic  clock,
  input  wire logic  clock_en,
  input  wire logic  reset_n,
  // pins and comparator results
  input  wire lfa_pins_s pins,
  // status outputs
  output lfa_status_s status,
  output lfa_lamps_s  lamps,
  output logic        lase_permit
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [`LFA_CNT_W-1:0] qual_step(
    input logic                  cond,
    input logic [`LFA_CNT_W-1:0] cnt
  );
    if (!cond) begin
      qual_step = '0;
    end else if (cnt == `LFA_CNT_W'(QUAL_CYC)) begin
      qual_step = cnt;
    end else begin
      qual_step = cnt + 1'b1;
    end
  endfunction

  function automatic lfa_mode_e mode_of(
    input logic board, input logic supply, input logic ot, input logic en
  );
    if (board) begin
      mode_of = LFA_M_BOARD;
    end else if (supply) begin
      mode_of = LFA_M_SUPPLY;
    end else if (ot) begin
      mode_of = LFA_M_OVERTEMP;
    end else if (!en) begin
      mode_of = LFA_M_INTERLOCK;
    end else begin
      mode_of = LFA_M_NORMAL;
    end
  endfunction

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  lfa_pins_s pins_meta_r;
  lfa_pins_s pins_s_r;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pins_meta_r <= '0;
      pins_s_r    <= '0;
    end else if (clock_en) begin
      pins_meta_r <= pins;
      pins_s_r    <= pins_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // supply qualification and fault latches
  // ----------------------------------------------------------------
  logic [`LFA_CNT_W-1:0] uv_cnt_r, ov_cnt_r;
  logic                  uv_r, ov_r, sense_r, ot_r, board_r;
  wire  [`LFA_CNT_W-1:0] uv_cnt_nxt = qual_step(pins_s_r.under_volt, uv_cnt_r);
  wire  [`LFA_CNT_W-1:0] ov_cnt_nxt = qual_step(pins_s_r.over_volt, ov_cnt_r);
  wire                   uv_hit     = pins_s_r.under_volt &&
                                      uv_cnt_r == `LFA_CNT_W'(QUAL_CYC);
  wire                   ov_hit     = pins_s_r.over_volt &&
                                      ov_cnt_r == `LFA_CNT_W'(QUAL_CYC);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      uv_cnt_r <= '0;
      ov_cnt_r <= '0;
      uv_r     <= 1'b0;
      ov_r     <= 1'b0;
      sense_r  <= 1'b0;
      ot_r     <= 1'b0;
      board_r  <= 1'b0;
    end else if (clock_en) begin
      uv_cnt_r <= uv_cnt_nxt;
      ov_cnt_r <= ov_cnt_nxt;
      uv_r     <= uv_r | uv_hit;
      ov_r     <= ov_r | ov_hit;
      sense_r  <= sense_r | pins_s_r.supply_monitor_fault;
      ot_r     <= ot_r | pins_s_r.over_temp;
      board_r  <= board_r | pins_s_r.board_fault;
    end
  end

  // ----------------------------------------------------------------
  // mode decode and blink code
  // ----------------------------------------------------------------
  wire        supply_any = uv_r | ov_r | sense_r;
  wire        any_fault  = supply_any | ot_r | board_r;
  lfa_mode_e  mode;
  wire  [1:0] code = sense_r ? `LFA_CODE_SENSE :
                     ov_r    ? `LFA_CODE_OV    :
                     uv_r    ? `LFA_CODE_UV    : 2'h0;

  assign mode = mode_of(board_r, supply_any, ot_r, pins_s_r.laser_enable);

  // ----------------------------------------------------------------
  // continuous flash and blink code engine
  // ----------------------------------------------------------------
  logic [`LFA_CNT_W-1:0] flash_cnt_r;
  logic                  flash_r;
  logic                  code_lamp;
  wire                   flash_wrap = (flash_cnt_r == `LFA_CNT_W'(FLASH_CYC - 1));

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      flash_cnt_r <= '0;
      flash_r     <= 1'b0;
    end else if (clock_en) begin
      flash_cnt_r <= flash_wrap ? '0 : flash_cnt_r + 1'b1;
      flash_r     <= flash_wrap ? ~flash_r : flash_r;
    end
  end

  lfa_blink #(
    .ON_CYC    (ON_CYC),
    .OFF_CYC   (OFF_CYC),
    .PAUSE_CYC (PAUSE_CYC)
  ) u_blink (
    .clock    (clock),
    .clock_en (clock_en),
    .reset_n  (reset_n),
    .code_i   (code),
    .active_i (mode == LFA_M_SUPPLY),
    .lamp_o   (code_lamp)
  );

  // ----------------------------------------------------------------
  // output pattern per mode
  // ----------------------------------------------------------------
  lfa_status_s status_nxt;
  lfa_lamps_s  lamps_nxt;
  logic        permit_nxt;

  always_comb begin
    status_nxt = '0;
    lamps_nxt  = '0;
    permit_nxt = 1'b0;
    case (mode)
      LFA_M_NORMAL: begin
        status_nxt.laser_ready = 1'b1;
        status_nxt.laser_ok    = 1'b1;
        status_nxt.lase_ind    = pins_s_r.pwm_active;
        status_nxt.voltage_ok  = 1'b1;
        status_nxt.temp_ok     = 1'b1;
        lamps_nxt.ready_lamp   = 1'b1;
        lamps_nxt.supply_lamp  = 1'b1;
        lamps_nxt.lase_lamp    = pins_s_r.pwm_active;
        permit_nxt             = 1'b1;
      end
      LFA_M_INTERLOCK: begin
        status_nxt.voltage_ok  = 1'b1;
        status_nxt.temp_ok     = 1'b1;
        lamps_nxt.supply_lamp  = 1'b1;
      end
      LFA_M_OVERTEMP: begin
        status_nxt.overtemp_fault = 1'b1;
        status_nxt.voltage_ok     = 1'b1;
        lamps_nxt.ready_lamp      = flash_r;
        lamps_nxt.supply_lamp     = 1'b1;
      end
      LFA_M_SUPPLY: begin
        status_nxt.supply_fault_out = 1'b1;
        status_nxt.temp_ok          = 1'b1;
        lamps_nxt.supply_lamp       = code_lamp;
      end
      LFA_M_BOARD: begin
        status_nxt.supply_fault_out = 1'b1;
        status_nxt.temp_ok          = 1'b1;
        lamps_nxt.ready_lamp        = flash_r;
        lamps_nxt.supply_lamp       = flash_r;
      end
      default: begin
        status_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      status      <= '0;
      lamps       <= '0;
      lase_permit <= 1'b0;
    end else if (clock_en) begin
      status      <= status_nxt;
      lamps       <= lamps_nxt;
      lase_permit <= permit_nxt;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  property p_ilk_off;
    clock_en && !pins_s_r.laser_enable && !any_fault
      |=> !lamps.ready_lamp && !lase_permit && !status.laser_ok && status.voltage_ok
          && status.temp_ok && lamps.supply_lamp;
  endproperty
  a_ilk_off: assert property (p_ilk_off) else $error("interlock pattern wrong");

  property p_ilk_recover;
    clock_en && pins_s_r.laser_enable && !any_fault
      |=> lamps.ready_lamp && lase_permit && status.laser_ready;
  endproperty
  a_ilk_recover: assert property (p_ilk_recover) else $error("enable did not restore ready");

  property p_ot_pattern;
    clock_en && ot_r && !supply_any && !board_r
      |=> status.overtemp_fault && !status.temp_ok && status.voltage_ok && !lase_permit
          && lamps.supply_lamp && !status.laser_ready;
  endproperty
  a_ot_pattern: assert property (p_ot_pattern) else $error("over-temperature pattern wrong");

  property p_ot_held;
    ot_r |=> ot_r;
  endproperty
  a_ot_held: assert property (p_ot_held) else $error("over-temperature latch dropped");

  sequence s_uv_set;
    !uv_r ##1 uv_r;
  endsequence

  property p_uv_qual;
    s_uv_set |-> $past(uv_cnt_r) == `LFA_CNT_W'(QUAL_CYC) && $past(pins_s_r.under_volt);
  endproperty
  a_uv_qual: assert property (p_uv_qual) else $error("under-voltage set early");

  sequence s_ov_set;
    !ov_r ##1 ov_r;
  endsequence

  property p_ov_qual;
    s_ov_set |-> $past(ov_cnt_r) == `LFA_CNT_W'(QUAL_CYC) && $past(pins_s_r.over_volt);
  endproperty
  a_ov_qual: assert property (p_ov_qual) else $error("over-voltage set early");

  property p_qual_restart;
    clock_en && !pins_s_r.under_volt |=> uv_cnt_r == '0;
  endproperty
  a_qual_restart: assert property (p_qual_restart) else $error("qualifier not restarted");

  property p_volt_held;
    (uv_r || ov_r || sense_r) |=> (uv_r || ov_r || sense_r);
  endproperty
  a_volt_held: assert property (p_volt_held) else $error("supply fault latch dropped");

  property p_supply_pattern;
    clock_en && supply_any && !board_r
      |=> status.supply_fault_out && !status.voltage_ok && status.temp_ok
          && !lamps.ready_lamp && !status.overtemp_fault && !lase_permit;
  endproperty
  a_supply_pattern: assert property (p_supply_pattern) else $error("supply pattern wrong");

  property p_board_pattern;
    clock_en && board_r
      |=> lamps.ready_lamp == lamps.supply_lamp && status.supply_fault_out
          && status.temp_ok && !status.voltage_ok && !lase_permit;
  endproperty
  a_board_pattern: assert property (p_board_pattern) else $error("board fault pattern wrong");

endmodule // lfa_top

`default_nettype wire

// ---- bench/lfa_ctrl_model.sv ----
// lfa_ctrl_model.sv: machine controller model driving enable and drive
// assumes the laser status outputs are fed back to it
`default_nettype none

module lfa_ctrl_model #(
  parameter int unsigned TICKLE_CYC = 8
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic reset_n,
  // request and feedback
  input  wire logic lase_req,
  input  wire logic laser_ok,
  // drive to the laser
  output logic      laser_enable,
  output logic      pwm_active
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] tickle_r;
  logic       en_r;
  logic       pwm_r;
  wire logic  tickle_done = (tickle_r == 8'(TICKLE_CYC));

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tickle_r <= 8'h00;
      en_r     <= 1'h0;
      pwm_r    <= 1'h0;
    end else begin
      en_r     <= lase_req;
      tickle_r <= !lase_req ? 8'h00 : tickle_done ? tickle_r : tickle_r + 8'h01;
      pwm_r    <= lase_req && tickle_done && laser_ok;
    end
  end

  assign laser_enable = en_r;
  assign pwm_active   = pwm_r;
endmodule // lfa_ctrl_model

`default_nettype wire

// ---- bench/lfa_top_test.sv ----
// lfa_top_test.sv: self-checking bench for the fault annunciator
// assumes lfa_pkg compiled first; counts shortened by parameters
`default_nettype none

module lfa_top_test;
  import lfa_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // setup
  // ----------------------------------------------------------------
  localparam int QUAL = 20, PAUSE = 12, ON = 4, OFF = 3, FLASH = 5, TICK = 8;
  logic        clock, clock_en, reset_n, lase_req;
  logic        ot, uv, ov, mon, brd, ctl_en, ctl_pwm;
  lfa_pins_s   pins;
  lfa_status_s status;
  lfa_lamps_s  lamps;
  lfa_lamps_s  lamps_hold;
  logic        lase_permit;
  int          n_errors, samples_checked;

  assign pins = {ctl_en, ot, uv, ov, mon, brd, ctl_pwm};

  lfa_top #(.QUAL_CYC(QUAL), .PAUSE_CYC(PAUSE), .ON_CYC(ON), .OFF_CYC(OFF),
            .FLASH_CYC(FLASH)) dut (
    .clock(clock), .clock_en(clock_en), .reset_n(reset_n), .pins(pins),
    .status(status), .lamps(lamps), .lase_permit(lase_permit));

  lfa_ctrl_model #(.TICKLE_CYC(TICK)) ctl (
    .clock(clock), .reset_n(reset_n), .lase_req(lase_req),
    .laser_ok(status.laser_ok), .laser_enable(ctl_en), .pwm_active(ctl_pwm));

  initial begin
    clock = 1'h0;
    forever #50 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clock);
      #1;
    end
  endtask

  task automatic cmp_status(input string what, input lfa_status_s exp);
    samples_checked++;
    if (status !== exp) begin
      n_errors++;
      $display("[FAIL] %s exp %h got %h", what, exp, status);
    end
  endtask

  task automatic cmp_lamps(input string what, input lfa_lamps_s exp, input lfa_lamps_s m);
    samples_checked++;
    if ((lamps & m) !== (exp & m)) begin
      n_errors++;
      $display("[FAIL] %s exp %h got %h", what, exp & m, lamps & m);
    end
  endtask

  task automatic cmp_bit(input string what, input logic exp);
    samples_checked++;
    if (lase_permit !== exp) begin
      n_errors++;
      $display("[FAIL] %s exp %b got %b", what, exp, lase_permit);
    end
  endtask

  task automatic cmp_count(input string what, input int exp, input int got);
    samples_checked++;
    if (exp != got) begin
      n_errors++;
      $display("[FAIL] %s exp %0d got %0d", what, exp, got);
    end
  endtask

  task automatic run_len(input int idx, input logic lvl, output int n);
    n = 0;
    while (lamps[idx] === lvl && n < 1000) begin
      tick(1);
      n++;
    end
    if (n >= 1000) begin
      n_errors++;
      $display("[FAIL] lamp %0d run exp below 1000 got %0d at level %b", idx, n, lvl);
      end_sim();
    end
  endtask

  task automatic blink(input int code);
    int d, on, pulses, k;
    d = 0;
    pulses = 0;
    run_len(1, 1'h1, on);
    for (k = 0; k < 12 && d < PAUSE; k++) begin
      run_len(1, 1'h0, d);
      if (d < PAUSE) run_len(1, 1'h1, on);
    end
    cmp_count("pause length", PAUSE, d);
    for (k = 0; k < 8; k++) begin
      run_len(1, 1'h1, on);
      pulses++;
      cmp_count("blink on", ON, on);
      run_len(1, 1'h0, d);
      if (d >= PAUSE) break;
      cmp_count("blink off", OFF, d);
    end
    cmp_count("blink count", code, pulses);
  endtask

  task automatic flash(input int idx);
    int h;
    run_len(idx, lamps[idx], h);
    run_len(idx, lamps[idx], h);
    cmp_count("flash first half", FLASH, h);
    run_len(idx, lamps[idx], h);
    cmp_count("flash second half", FLASH, h);
  endtask

  task automatic power_cycle();
    reset_n = 1'h0;
    tick(2);
    reset_n = 1'h1;
    tick(TICK + 8);
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    $display("[FAIL] watchdog exp finished got %0d cycles", 20000);
    end_sim();
  end

  initial begin
    n_errors = 0;
    samples_checked = 0;
    {clock_en, reset_n, lase_req, ot, uv, ov, mon, brd} = 8'h80;
    tick(4);
    cmp_status("in reset", 7'h00);
    reset_n = 1'h1;
    tick(4);
    cmp_status("interlock", 7'h03);
    cmp_lamps("interlock lamps", 3'h2, 3'h7);
    cmp_bit("interlock permit", 1'h0);
    lase_req = 1'h1;
    tick(TICK + 6);
    cmp_status("normal", 7'h67);
    cmp_lamps("normal lamps", 3'h7, 3'h7);
    cmp_bit("normal permit", 1'h1);
    lase_req = 1'h0;
    tick(5);
    cmp_status("enable open", 7'h03);
    lase_req = 1'h1;
    tick(5);
    cmp_lamps("enable back", 3'h6, 3'h6);
    cmp_bit("enable back permit", 1'h1);
    tick(TICK + 4);
    uv = 1'h1;
    tick(QUAL);
    uv = 1'h0;
    tick(2);
    uv = 1'h1;
    tick(QUAL);
    uv = 1'h0;
    tick(5);
    cmp_status("short low supply", 7'h67);
    uv = 1'h1;
    tick(QUAL + 1);
    uv = 1'h0;
    tick(5);
    cmp_status("under voltage", 7'h11);
    cmp_lamps("under voltage lamps", 3'h0, 3'h5);
    cmp_bit("under voltage permit", 1'h0);
    blink(1);
    cmp_status("under voltage held", 7'h11);
    power_cycle();
    cmp_status("after cycle", 7'h67);
    cmp_lamps("after cycle lamps", 3'h7, 3'h7);
    ov = 1'h1;
    tick(QUAL + 1);
    ov = 1'h0;
    tick(5);
    cmp_status("over voltage", 7'h11);
    blink(2);
    power_cycle();
    mon = 1'h1;
    tick(3);
    mon = 1'h0;
    tick(5);
    cmp_status("monitor fault", 7'h11);
    blink(3);
    cmp_status("monitor held", 7'h11);
    power_cycle();
    ot = 1'h1;
    tick(3);
    ot = 1'h0;
    tick(5);
    cmp_status("over temp", 7'h0a);
    cmp_lamps("over temp lamps", 3'h2, 3'h3);
    cmp_bit("over temp permit", 1'h0);
    flash(2);
    cmp_status("over temp held", 7'h0a);
    power_cycle();
    cmp_status("temp cleared", 7'h67);
    cmp_lamps("ready steady", 3'h7, 3'h7);
    tick(FLASH);
    cmp_lamps("ready still steady", 3'h7, 3'h7);
    cmp_bit("temp cleared permit", 1'h1);
    brd = 1'h1;
    tick(3);
    brd = 1'h0;
    tick(5);
    cmp_status("board fault", 7'h11);
    cmp_bit("board permit", 1'h0);
    clock_en = 1'h0;
    lamps_hold = lamps;
    tick(FLASH + 2);
    cmp_lamps("lamps frozen", lamps_hold, 3'h7);
    clock_en = 1'h1;
    flash(2);
    flash(1);
    end_sim();
  end
endmodule // lfa_top_test

`default_nettype wire
